/* File: host_interrupt_mask_event_regs.sv */
`timescale 1ns/1ps
`include "host_irq_defines.svh"

module host_interrupt_mask_event_regs #(
	parameter int TX_CTX = 8,
	parameter int RX_CTX = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// register access
	input wire host_irq_pkg::reg_req_t req_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o,
	// context completion levels and main events
	input wire host_irq_pkg::ctx_irq_t ctx_irq_i,
	input wire logic [31:0] main_irq_events_i,
	// summaries and external interrupt
	output logic tx_context_summary_irq_o,
	output logic rx_context_summary_irq_o,
	output logic irq_o
);
	import host_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// write-one-to-set / write-one-to-clear update of a word
	function automatic logic [31:0] w1_update(input logic [31:0] cur,
		input logic [31:0] data, input logic set, input logic clr);
		logic [31:0] s;
		logic [31:0] c;
		s = set ? data : `RST_WORD;
		c = clr ? data : `RST_WORD;
		return (cur | s) & ~c;
	endfunction

	function automatic logic hit(input reg_req_t r, input logic [7:0] ofs);
		return r.wr && (r.addr == ofs);
	endfunction

	// unlatched summary of the flags that are also enabled
	function automatic logic any_enabled(input logic [31:0] flags,
		input logic [31:0] enables);
		return |(flags & enables);
	endfunction

	// context words sit in the low bits; unused upper bits read as zero
	function automatic logic [31:0] pad_tx(input logic [TX_CTX-1:0] v);
		return 32'(v);
	endfunction

	function automatic logic [31:0] pad_rx(input logic [RX_CTX-1:0] v);
		return 32'(v);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// state

	logic [31:0] main_irq_enables_ff;
	logic [TX_CTX-1:0] tx_context_enables_ff;
	logic [RX_CTX-1:0] rx_context_enables_ff;
	logic [TX_CTX-1:0] tx_context_flags_ff;
	logic [RX_CTX-1:0] rx_context_flags_ff;
	logic [TX_CTX-1:0] tx_prev_ff;
	logic [RX_CTX-1:0] rx_prev_ff;
	logic [TX_CTX-1:0] tx_rise;
	logic [RX_CTX-1:0] rx_rise;
	logic [31:0] events_all;
	logic [31:0] tx_flags_w;
	logic [31:0] rx_flags_w;
	logic [31:0] tx_en_w;
	logic [31:0] rx_en_w;
	logic [31:0] rd_word;
	logic gate_on;
	logic main_pending;

	assign tx_flags_w = pad_tx(tx_context_flags_ff);
	assign rx_flags_w = pad_rx(rx_context_flags_ff);
	assign tx_en_w = pad_tx(tx_context_enables_ff);
	assign rx_en_w = pad_rx(rx_context_enables_ff);

	////////////////////////////////////////////////////////////////////////
	// write decode

	// one strobe per register offset; set and clear offsets differ, so a
	// set and a clear of the same register never meet in one cycle
	logic wr_main_set;
	logic wr_main_clr;
	logic wr_tx_en_set;
	logic wr_tx_en_clr;
	logic wr_rx_en_set;
	logic wr_rx_en_clr;
	logic wr_tx_fl_set;
	logic wr_tx_fl_clr;
	logic wr_rx_fl_set;
	logic wr_rx_fl_clr;

	assign wr_main_set = hit(req_i, `OFS_MAIN_MASK_SET);
	assign wr_main_clr = hit(req_i, `OFS_MAIN_MASK_CLEAR);
	assign wr_tx_en_set = hit(req_i, `OFS_TX_MASK_SET);
	assign wr_tx_en_clr = hit(req_i, `OFS_TX_MASK_CLEAR);
	assign wr_rx_en_set = hit(req_i, `OFS_RX_MASK_SET);
	assign wr_rx_en_clr = hit(req_i, `OFS_RX_MASK_CLEAR);
	assign wr_tx_fl_set = hit(req_i, `OFS_TX_EVENT_SET);
	assign wr_tx_fl_clr = hit(req_i, `OFS_TX_EVENT_CLEAR);
	assign wr_rx_fl_set = hit(req_i, `OFS_RX_EVENT_SET);
	assign wr_rx_fl_clr = hit(req_i, `OFS_RX_EVENT_CLEAR);

	////////////////////////////////////////////////////////////////////////
	// edge detection of context completions

	// engines pulse or hold a level per completion; only the rising edge
	// counts, so a held level cannot re-set a flag after software clears it
	// history resets low, matching the idle level of the inputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_prev_ff <= '0;
		end else begin
			tx_prev_ff <= ctx_irq_i.tx[TX_CTX-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_prev_ff <= '0;
		end else begin
			rx_prev_ff <= ctx_irq_i.rx[RX_CTX-1:0];
		end
	end

	assign tx_rise = ctx_irq_i.tx[TX_CTX-1:0] & ~tx_prev_ff;
	assign rx_rise = ctx_irq_i.rx[RX_CTX-1:0] & ~rx_prev_ff;

	////////////////////////////////////////////////////////////////////////
	// enable registers

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			main_irq_enables_ff <= `RST_WORD;
		end else begin
			main_irq_enables_ff <= w1_update(main_irq_enables_ff,
				req_i.wdata, wr_main_set, wr_main_clr);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_context_enables_ff <= '0;
		end else begin
			tx_context_enables_ff <= TX_CTX'(w1_update(tx_en_w,
				req_i.wdata, wr_tx_en_set, wr_tx_en_clr));
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_context_enables_ff <= '0;
		end else begin
			rx_context_enables_ff <= RX_CTX'(w1_update(rx_en_w,
				req_i.wdata, wr_rx_en_set, wr_rx_en_clr));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// context flag registers

	// an edge in the cycle of a clear write keeps the flag set, so a
	// completion that races the clear is never lost
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tx_context_flags_ff <= '0;
		end else begin
			tx_context_flags_ff <= TX_CTX'(w1_update(tx_flags_w,
				req_i.wdata, wr_tx_fl_set, wr_tx_fl_clr)) | tx_rise;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_context_flags_ff <= '0;
		end else begin
			rx_context_flags_ff <= RX_CTX'(w1_update(rx_flags_w,
				req_i.wdata, wr_rx_fl_set, wr_rx_fl_clr)) | rx_rise;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// summaries and external interrupt

	assign tx_context_summary_irq_o = any_enabled(tx_flags_w, tx_en_w);
	assign rx_context_summary_irq_o = any_enabled(rx_flags_w, rx_en_w);

	// summaries take the place of the outside bits at their positions
	always_comb begin
		events_all = main_irq_events_i;
		events_all[`BIT_TX_SUMMARY] = tx_context_summary_irq_o;
		events_all[`BIT_RX_SUMMARY] = rx_context_summary_irq_o;
		events_all[`BIT_GLOBAL_GATE] = `RST_BIT;
	end

	// gate bit is excluded from the event AND so it only acts as a gate
	assign gate_on = main_irq_enables_ff[`BIT_GLOBAL_GATE];
	assign main_pending = any_enabled(events_all, main_irq_enables_ff);

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			irq_o <= `RST_BIT;
		end else begin
			irq_o <= gate_on && main_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	always_comb begin
		rd_word = `RST_WORD;
		case (req_i.addr)
			`OFS_MAIN_MASK_SET, `OFS_MAIN_MASK_CLEAR: begin
				rd_word = main_irq_enables_ff;
			end
			`OFS_TX_EVENT_SET: begin
				rd_word = tx_flags_w;
			end
			// clear offset reads show the enabled flags only
			`OFS_TX_EVENT_CLEAR: begin
				rd_word = tx_flags_w & tx_en_w;
			end
			`OFS_TX_MASK_SET, `OFS_TX_MASK_CLEAR: begin
				rd_word = tx_en_w;
			end
			`OFS_RX_EVENT_SET: begin
				rd_word = rx_flags_w;
			end
			`OFS_RX_EVENT_CLEAR: begin
				rd_word = rx_flags_w & rx_en_w;
			end
			`OFS_RX_MASK_SET, `OFS_RX_MASK_CLEAR: begin
				rd_word = rx_en_w;
			end
			default: begin
				rd_word = `RST_WORD;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rvalid_o <= `RST_BIT;
		end else begin
			rvalid_o <= req_i.rd;
		end
	end

	// read data holds between reads so a slow host can sample it late
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdata_o <= `RST_WORD;
		end else if (req_i.rd) begin
			rdata_o <= rd_word;
		end
	end

endmodule // host_interrupt_mask_event_regs

/* File: host_irq_defines.svh */
`ifndef HOST_IRQ_DEFINES_SVH
`define HOST_IRQ_DEFINES_SVH

// register byte offsets
`define OFS_TX_EVENT_CLEAR 8'h84
`define OFS_MAIN_MASK_SET 8'h88
`define OFS_MAIN_MASK_CLEAR 8'h8C
`define OFS_TX_EVENT_SET 8'h90
`define OFS_TX_MASK_SET 8'h98
`define OFS_TX_MASK_CLEAR 8'h9C
`define OFS_RX_EVENT_SET 8'hA0
`define OFS_RX_EVENT_CLEAR 8'hA4
`define OFS_RX_MASK_SET 8'hA8
`define OFS_RX_MASK_CLEAR 8'hAC

// field positions in the main event and mask words
`define BIT_GLOBAL_GATE 31
`define BIT_TX_SUMMARY 6
`define BIT_RX_SUMMARY 7

// reset values
`define RST_WORD 32'h0000_0000
`define RST_BIT 1'h0

`endif

/* File: host_irq_pkg.sv */
package host_irq_pkg;

	// one register access, taken in the cycle its strobe is high
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	// per-context completion inputs from the isochronous engines
	typedef struct packed {
		logic [7:0] tx;
		logic [3:0] rx;
	} ctx_irq_t;

endpackage

/* File: irq_regs_checker.sv */
`timescale 1ns/1ps
module irq_regs_checker import host_irq_pkg::*; #(
	parameter int TX_CTX = 8,
	parameter int RX_CTX = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// register access
	input wire host_irq_pkg::reg_req_t req_i,
	input wire logic [31:0] rdata_o,
	input wire logic rvalid_o,
	// sources
	input wire host_irq_pkg::ctx_irq_t ctx_irq_i,
	input wire logic [31:0] main_irq_events_i,
	// interrupts
	input wire logic tx_context_summary_irq_o,
	input wire logic rx_context_summary_irq_o,
	input wire logic irq_o
);
	logic [31:0] mask_ff;
	logic [11:0] ctx_ff;
	wire logic w = req_i.wr;
	wire logic [7:0] a = req_i.addr;
	wire logic tx_s = tx_context_summary_irq_o;
	wire logic rx_s = rx_context_summary_irq_o;
	wire logic [11:0] up = ctx_irq_i & ~ctx_ff;
	// summaries stand in for main event bits 6 and 7; bit 31 never counts
	wire logic [31:0] ev = {1'h0, main_irq_events_i[30:8], rx_s, tx_s,
		main_irq_events_i[5:0]};
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) mask_ff <= '0;
		else if (w && a == 8'h88) mask_ff <= mask_ff | req_i.wdata;
		else if (w && a == 8'h8C) mask_ff <= mask_ff & ~req_i.wdata;
	end
	always_ff @(posedge clk_i) begin
		ctx_ff <= reset_n_i ? ctx_irq_i : 12'h000;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	rd_pulse_a: assert property (rvalid_o == $past(req_i.rd))
		else $error("read answer misplaced");
	irq_gate_a: assert property (
		irq_o == $past(mask_ff[31] && |(mask_ff & ev)))
		else $error("external interrupt wrong");
	mask_read_a: assert property (
		rvalid_o && $past(a == 8'h88 || a == 8'h8C) |->
		rdata_o == $past(mask_ff))
		else $error("main mask read wrong");
	unmapped_rd_a: assert property (
		rvalid_o && $past(a > 8'hAC || a < 8'h84) |-> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	tx_rise_a: assert property (
		$rose(tx_s) |-> $past(up[11:4] != 8'h00 ||
		w && (a == 8'h90 || a == 8'h98))) else $error("tx summary rose");
	tx_fall_a: assert property (
		$fell(tx_s) |-> $past(w && (a == 8'h84 || a == 8'h9C)))
		else $error("tx summary fell");
	rx_rise_a: assert property (
		$rose(rx_s) |-> $past(up[3:0] != 4'h0 ||
		w && (a == 8'hA0 || a == 8'hA8))) else $error("rx summary rose");
	rx_fall_a: assert property (
		$fell(rx_s) |-> $past(w && (a == 8'hA4 || a == 8'hAC)))
		else $error("rx summary fell");
	rdata_hold_a: assert property (!rvalid_o |-> $stable(rdata_o))
		else $error("read data moved");
endmodule // irq_regs_checker

/* File: tb_host_interrupt_mask_event_regs.sv */
`timescale 1ns/1ps
bind host_interrupt_mask_event_regs irq_regs_checker #(.TX_CTX(TX_CTX),
	.RX_CTX(RX_CTX)) i_irq_regs_checker (.clk_i, .reset_n_i, .req_i,
	.rdata_o, .rvalid_o, .ctx_irq_i, .main_irq_events_i,
	.tx_context_summary_irq_o, .rx_context_summary_irq_o, .irq_o);
module tb_host_interrupt_mask_event_regs;
	import host_irq_pkg::*;
	logic clk_i, reset_n_i, rvalid_o, irq_o, tx_o, rx_o;
	reg_req_t req_i;
	ctx_irq_t ctx_irq_i;
	logic [31:0] main_irq_events_i, rdata_o, s, e, m;
	logic [31:0] q[$];
	logic [7:0] a, c;
	int bad_count, tests_run, cyc, j;
	host_interrupt_mask_event_regs i_host_interrupt_mask_event_regs (.clk_i,
		.reset_n_i, .req_i, .rdata_o, .rvalid_o, .ctx_irq_i,
		.main_irq_events_i, .tx_context_summary_irq_o(tx_o),
		.rx_context_summary_irq_o(rx_o), .irq_o);
	initial begin
		clk_i = 0;
		forever #20 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lf(input logic [31:0] v);
		return v[0] ? (v >> 1) ^ 32'h80200003 : v >> 1;
	endfunction
	task results;
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] x, input logic [31:0] y);
		tests_run++;
		if (x !== y) begin
			bad_count++;
			$display("mismatch %0t %h %h", $time, x, y);
		end
	endtask
	task tick(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// idle cycle after each access so no strobe is driven twice in a step
	task acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
		req_i = '{w, !w, ad, d};
		if (!w) q.push_back(d);
		tick();
		req_i = '0;
		tick();
	endtask
	always @(negedge clk_i) begin
		if (rvalid_o === 1'b1) chk(rdata_o, q.pop_front());
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 3000) begin
			bad_count++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		req_i = '0;
		ctx_irq_i = '0;
		main_irq_events_i = '0;
		reset_n_i = 0;
		s = 32'h000123FD;
		tick(3);
		reset_n_i = 1;
		for (j = 8'h84; j <= 8'hB0; j += 4) acc(0, j[7:0], 0);
		for (j = 0; j < 3; j++) begin
			a = 8'h88 + 8'(j * 16);
			m = j == 0 ? 32'hFFFFFFFF : (j == 1 ? 32'hFF : 32'hF);
			s = lf(s);
			acc(1, a, s);
			acc(0, a, s & m);
			acc(0, a + 8'h4, s & m);
			acc(1, a + 8'h4, s);
			acc(0, a, 0);
		end
		acc(1, 8'h88, 32'h800000C0);
		acc(1, 8'h98, 32'hFF);
		acc(1, 8'hA8, 32'hF);
		for (j = 0; j < 12; j++) begin
			ctx_irq_i = 12'h1 << j;
			a = j > 3 ? 8'h90 : 8'hA0;
			c = j > 3 ? 8'h84 : 8'hA4;
			e = j > 3 ? 1 << (j - 4) : 1 << j;
			tick(2);
			chk(tx_o, j > 3);
			chk(rx_o, j < 4);
			chk(irq_o, 1);
			acc(0, a, e);
			acc(1, c, 0);
			acc(0, a, e);
			acc(1, c, e);
			acc(0, a, 0);
			chk(irq_o, 0);
			ctx_irq_i = '0;
			tick();
		end
		acc(1, 8'h8C, 32'h80000000);
		s = lf(s);
		acc(1, 8'h90, s & 32'hFF);
		acc(1, 8'hA0, 32'h5);
		chk(irq_o, 0);
		acc(0, 8'h84, s & 32'hFF);
		acc(1, 8'h84, 32'hFFFFFFFF);
		acc(1, 8'hA4, 32'hFFFFFFFF);
		acc(1, 8'h88, lf(s) | 32'h80000000);
		for (j = 0; j < 40; j++) begin
			s = lf(s);
			main_irq_events_i = s;
			tick();
		end
		results();
	end
endmodule // tb_host_interrupt_mask_event_regs
